// [shared/lsw_defines.vh]
// Summary of operation
// - control bit 7 gates the buzzer tone onto the tone output pin.
// - tone select bits 5:4 pick 2, 4, 8 or 16 kHz.
// - control bit 3 reads back the live subsystem oscillator pin level.
// - bit 2 runs the watch timer; clearing it stops and clears the divider.
// - bit 1 picks a 0.5 s or 3.91 ms interval flag period.
// - bit 0 picks main clock / 128 or the subsystem clock as watch clock.
// - lcd mode register sets frame rate, duty and segment/port pin split.
// - lcd control register sets display on, bias current, clock/sync output.
// - display RAM reaches segment outputs with no CPU involvement.
// - subsystem-clocked scan keeps running with main oscillator stopped.
// - display RAM is bank 2, written by bit, nibble or byte.
// - a 1 bit lights its dot, a 0 bit blanks it.
// - hardware fetches display RAM rows paced by the lcd scan clock.
// - display RAM unused by the panel is write-only storage; cpu reads of bank 2 return 00.
// - row n lives at 200H + n*10H, nibbles 0 to 0DH, bit 0 lowest.
// - duty 1/16, 1/12, 1/8 scans rows 0-15, 0-11, 0-7.
// - in 1/8 duty rows 8 to 15 are released as port pins.
// - in 1/12 duty rows 12 to 15 are released as port pins.
// - 56 column outputs and 16 row outputs, up to 896 dots.
// - reset clears the control register except the live level bit.
`ifndef LSW_DEFINES_VH
`define LSW_DEFINES_VH

// register nibble addresses
`define LSW_ADDR_WT_LO    12'h0F88
`define LSW_ADDR_WT_HI    12'h0F89
`define LSW_ADDR_LCD_MODE_REGISTER_LO  12'h0F8C
`define LSW_ADDR_LCD_MODE_REGISTER_HI  12'h0F8D
`define LSW_ADDR_LCD_CONTROL_REGISTER     12'h0F8E
`define LSW_RAM_BANK      4'h2

// cpu access width codes
`define LSW_WR_BIT        2'h0
`define LSW_WR_NIBBLE     2'h1
`define LSW_WR_BYTE       2'h2

// watch timer control fields (low nibble / high nibble)
`define LSW_WT_SUBSEL     0
`define LSW_WT_FAST       1
`define LSW_WT_RUN        2
`define LSW_WT_TONE_EN    3
`define LSW_WT_RESET      4'h0

// watch clock rates and intervals
`define LSW_MAIN_PRESCALE 7'h7F
`define LSW_FW_HZ         64'd32768
`define LSW_IVL_NORM_US   64'd500000
`define LSW_IVL_FAST_US   64'd3910
`define LSW_US_PER_S      64'd1000000
`define LSW_BUZ_BASE_BIT  4'h3

// lcd mode / control fields
`define LSW_LM_DUTY16     2
`define LSW_LC_DUTY12     3
`define LSW_LC_CLKOUT     2
`define LSW_DISP_ALL_ON   2'h1
`define LSW_DISP_NORMAL   2'h3
`define LSW_DISP_OFF      2'h0
`define LSW_LCK_BASE8     4'h7
`define LSW_LCK_BASE      4'h6

// panel geometry
`define LSW_NIBS_PER_ROW  4'hE
`define LSW_ROWS_8        4'h7
`define LSW_ROWS_12       4'hB
`define LSW_ROWS_16       4'hF
`define LSW_SEG_GROUPS    3'h4

`endif

// [logic/lsw_watch_div.v]
`timescale 1ns/10ps
`include "lsw_defines.vh"

module lsw_watch_div (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // control
  input  wire        runEn,
  input  wire        subSel,
  input  wire        fastMode,
  input  wire [1:0]  toneSel,
  // source ticks
  input  wire        mainOscTick,
  input  wire        subTick,
  // results
  output wire        fwTick,
  output reg  [14:0] divCnt_r,
  output wire        intervalPulse,
  output reg         toneLevel_r
);

  // rounded tick counts worked out wide, then cut to the divider width
  localparam [63:0] NORM_WIDE  = (`LSW_FW_HZ * `LSW_IVL_NORM_US
                                  + `LSW_US_PER_S / 2) / `LSW_US_PER_S;
  localparam [63:0] FAST_WIDE  = (`LSW_FW_HZ * `LSW_IVL_FAST_US
                                  + `LSW_US_PER_S / 2) / `LSW_US_PER_S;
  localparam [14:0] NORM_TICKS = NORM_WIDE[14:0];
  localparam [14:0] FAST_TICKS = FAST_WIDE[14:0];

  reg  [6:0]  pre_r;
  wire [14:0] ivlMask;
  wire [3:0]  toneBit;

  // main source divides by 128, sub source passes straight through
  assign fwTick = runEn & (subSel ? subTick
                  : (mainOscTick & (pre_r == `LSW_MAIN_PRESCALE)));
  assign ivlMask = (fastMode ? FAST_TICKS : NORM_TICKS) - 15'h0001;
  assign intervalPulse = fwTick & ((divCnt_r & ivlMask) == ivlMask);
  assign toneBit = `LSW_BUZ_BASE_BIT - {2'h0, toneSel};

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_r       <= 7'h00;
      divCnt_r    <= 15'h0000;
      toneLevel_r <= 1'b0;
    end else if (!runEn) begin
      // stopped timer holds every divider stage cleared
      pre_r       <= 7'h00;
      divCnt_r    <= 15'h0000;
      toneLevel_r <= 1'b0;
    end else begin
      if (mainOscTick)
        pre_r <= pre_r + 7'h01;
      if (fwTick)
        divCnt_r <= divCnt_r + 15'h0001;
      toneLevel_r <= divCnt_r[toneBit];
    end
  end

endmodule // lsw_watch_div

// [logic/lsw_disp_ram.v]
`timescale 1ns/10ps

module lsw_disp_ram (
  // clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // cpu write
  input  wire       wrLo,
  input  wire       wrHi,
  input  wire [7:0] wrAddr,
  input  wire [3:0] maskLo,
  input  wire [3:0] dataLo,
  input  wire [3:0] dataHi,
  // cpu read, byte wide: addressed nibble low, odd nibble of its pair high
  input  wire [7:0] rdAddr,
  output reg  [7:0] rdData_r,
  // scan read
  input  wire [7:0] scanAddr,
  output reg  [3:0] scanData_r
);

  // whole bank is plain storage; panel only reads what it scans
  reg [3:0] mem [0:255];
  wire [7:0] hiAddr;

  assign hiAddr = {wrAddr[7:1], 1'b1};

  always @(posedge clk) begin
    if (wrLo)
      mem[wrAddr] <= (mem[wrAddr] & ~maskLo) | (dataLo & maskLo);
    if (wrHi)
      mem[hiAddr] <= dataHi;
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_r   <= 8'h00;
      scanData_r <= 4'h0;
    end else begin
      rdData_r   <= {mem[{rdAddr[7:1], 1'b1}], mem[rdAddr]};
      scanData_r <= mem[scanAddr];
    end
  end

endmodule // lsw_disp_ram

// [logic/lsw_scan_watch.v]
`timescale 1ns/10ps
`include "lsw_defines.vh"

module lsw_scan_watch (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // cpu data memory port
  input  wire [11:0] memAddr,
  input  wire        memWrEn,
  input  wire [1:0]  memWrMode,
  input  wire [1:0]  memBitSel,
  input  wire [7:0]  memWrData,
  output reg  [7:0]  memRdData_r,
  // oscillator sources
  input  wire        mainOscTick,
  input  wire        subOscInputPin,
  // interval flag
  output reg         watchIntervalFlag_r,
  input  wire        intervalFlagClr,
  // buzzer
  output reg         toneOutputPin_r,
  // panel
  output reg  [55:0] columnDrive_r,
  output reg  [15:0] rowDrive_r,
  output reg  [3:0]  columnPortRelease_r,
  output reg  [15:0] rowPortRelease_r,
  output reg         biasCurrentOn_r,
  output reg  [1:0]  contrastMode_r,
  output reg         lcdFrameClock_r,
  output reg         lcdSyncOut_r
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_FETCH = 2'h1;
  localparam [1:0] ST_SHOW  = 2'h2;

  // registers
  reg  [3:0]  wtLo_r;
  reg  [3:0]  wtHi_r;
  reg  [3:0]  lmLo_r;
  reg  [3:0]  lmHi_r;
  reg  [3:0]  lcd_control_register_r;
  reg         runDly_r;
  // pin synchroniser
  reg         xtSync1_r;
  reg         xtSync2_r;
  reg         xtPrev_r;
  // scan engine
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [3:0]  row_r;
  reg  [3:0]  fetchIdx_r;
  reg  [55:0] rowBuf_r;
  reg         lastReadWasRam_r;
  reg  [3:0]  regRdLo_r;
  reg  [3:0]  regRdHi_r;

  wire        subTick;
  wire        fwTick;
  wire [14:0] divCnt;
  wire        intervalPulse;
  wire        toneLevel;
  wire        wtRun;
  wire        isByte;
  wire [3:0]  maskLo;
  wire [3:0]  dataLo;
  wire [3:0]  dataHi;
  wire        ramSel;
  wire        ramWrLo;
  wire        ramWrHi;
  wire [3:0]  lastRow;
  wire [3:0]  lckExp;
  wire        lcdTick;
  wire        dispOn;
  wire [1:0]  dispMode;
  wire [3:0]  nextRow;
  wire [3:0]  scanNib;
  wire [2:0]  segPorts;

  // bit mask for the addressed nibble
  function [3:0] bitMask;
    input [1:0] mode;
    input [1:0] sel;
    begin
      if (mode == `LSW_WR_BIT)
        bitMask = 4'h1 << sel;
      else
        bitMask = 4'hF;
    end
  endfunction

  // next value of a register nibble at address a
  function [3:0] updNib;
    input [3:0]  old;
    input [11:0] a;
    begin
      if (memWrEn && memAddr == a)
        updNib = (old & ~maskLo) | (dataLo & maskLo);
      else if (memWrEn && isByte && {memAddr[11:1], 1'b1} == a)
        updNib = dataHi;
      else
        updNib = old;
    end
  endfunction

  // one-hot row select
  function [15:0] rowOneHot;
    input [3:0] r;
    begin
      rowOneHot = 16'h0001 << r;
    end
  endfunction

  assign isByte = (memWrMode == `LSW_WR_BYTE);
  assign maskLo = isByte ? 4'hF : bitMask(memWrMode, memBitSel);
  assign dataLo = (memWrMode == `LSW_WR_BIT) ? {4{memWrData[0]}}
                                             : memWrData[3:0];
  assign dataHi = memWrData[7:4];

  // subsystem pin: two flops, then edge detect on the second only
  assign subTick = xtSync2_r & ~xtPrev_r;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xtSync1_r <= 1'b0;
      xtSync2_r <= 1'b0;
      xtPrev_r  <= 1'b0;
    end else begin
      xtSync1_r <= subOscInputPin;
      xtSync2_r <= xtSync1_r;
      xtPrev_r  <= xtSync2_r;
    end
  end

  // register writes; watch timer bit 3 and bit 6 hold no storage
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wtLo_r   <= `LSW_WT_RESET;
      wtHi_r   <= `LSW_WT_RESET;
      lmLo_r   <= 4'h0;
      lmHi_r   <= 4'h0;
      lcd_control_register_r   <= 4'h0;
      runDly_r <= 1'b0;
    end else begin
      wtLo_r   <= updNib(wtLo_r, `LSW_ADDR_WT_LO) & 4'h7;
      wtHi_r   <= updNib(wtHi_r, `LSW_ADDR_WT_HI) & 4'hB;
      lmLo_r   <= updNib(lmLo_r, `LSW_ADDR_LCD_MODE_REGISTER_LO);
      lmHi_r   <= updNib(lmHi_r, `LSW_ADDR_LCD_MODE_REGISTER_HI);
      lcd_control_register_r   <= updNib(lcd_control_register_r, `LSW_ADDR_LCD_CONTROL_REGISTER);
      runDly_r <= wtRun;
    end
  end

  assign wtRun = wtLo_r[`LSW_WT_RUN];

  lsw_watch_div u_div (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .runEn        (wtRun),
    .subSel       (wtLo_r[`LSW_WT_SUBSEL]),
    .fastMode     (wtLo_r[`LSW_WT_FAST]),
    .toneSel      (wtHi_r[1:0]),
    .mainOscTick  (mainOscTick),
    .subTick      (subTick),
    .fwTick       (fwTick),
    .divCnt_r     (divCnt),
    .intervalPulse(intervalPulse),
    .toneLevel_r  (toneLevel)
  );

  // flag rises on start and every interval; set beats a same-cycle clear
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      watchIntervalFlag_r <= 1'b0;
    else if (intervalPulse || (wtRun && !runDly_r))
      watchIntervalFlag_r <= 1'b1;
    else if (intervalFlagClr)
      watchIntervalFlag_r <= 1'b0;
  end

  // port latch and direction live outside this block
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      toneOutputPin_r <= 1'b0;
    else
      toneOutputPin_r <= wtHi_r[`LSW_WT_TONE_EN] & toneLevel;
  end

  // bank 2 display ram, shared with general storage
  assign ramSel  = (memAddr[11:8] == `LSW_RAM_BANK);
  assign ramWrLo = memWrEn & ramSel;
  assign ramWrHi = memWrEn & ramSel & isByte & ~memAddr[0];

  lsw_disp_ram u_ram (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .wrLo      (ramWrLo),
    .wrHi      (ramWrHi),
    .wrAddr    (memAddr[7:0]),
    .maskLo    (maskLo),
    .dataLo    (dataLo),
    .dataHi    (dataHi),
    .rdAddr    (memAddr[7:0]),
    .rdData_r  (),
    .scanAddr  ({row_r, fetchIdx_r}),
    .scanData_r(scanNib)
  );

  // register readback, one cycle after the address
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdLo_r        <= 4'h0;
      regRdHi_r        <= 4'h0;
      lastReadWasRam_r <= 1'b0;
    end else begin
      lastReadWasRam_r <= ramSel;
      regRdLo_r        <= 4'h0;
      regRdHi_r        <= 4'h0;
      case ({memAddr[11:1], 1'b0})
        `LSW_ADDR_WT_LO: begin
          regRdLo_r <= {xtSync2_r, wtLo_r[2:0]};
          regRdHi_r <= wtHi_r;
        end
        `LSW_ADDR_LCD_MODE_REGISTER_LO: begin
          regRdLo_r <= lmLo_r;
          regRdHi_r <= lmHi_r;
        end
        `LSW_ADDR_LCD_CONTROL_REGISTER: begin
          regRdLo_r <= lcd_control_register_r;
        end
        default: begin
          regRdLo_r <= 4'h0;
        end
      endcase
    end
  end

  // odd nibble reads come back in the high half; bank 2 reads return 00
  always @* begin
    memRdData_r = {regRdHi_r, regRdLo_r};
    if (lastReadWasRam_r)
      memRdData_r = 8'h00;
  end

  // duty and scan clock; scan stops with the watch timer
  assign lastRow = lcd_control_register_r[`LSW_LC_DUTY12] ? `LSW_ROWS_12
                 : (lmLo_r[`LSW_LM_DUTY16] ? `LSW_ROWS_16
                                           : `LSW_ROWS_8);
  assign lckExp = ((lastRow == `LSW_ROWS_8) ? `LSW_LCK_BASE8
                                            : `LSW_LCK_BASE)
                  - {2'h0, lmHi_r[0], lmLo_r[3]};
  // fw and the divider keep going from the sub clock alone
  assign lcdTick = fwTick & ((divCnt & ((15'h0001 << lckExp) - 15'h0001))
                   == ((15'h0001 << lckExp) - 15'h0001));
  assign nextRow  = (row_r >= lastRow) ? 4'h0 : row_r + 4'h1;
  assign dispOn   = (lcd_control_register_r[1:0] != 2'h0);
  assign dispMode = lmLo_r[1:0];
  assign segPorts = (lmHi_r[3:1] > `LSW_SEG_GROUPS) ? `LSW_SEG_GROUPS
                                                    : lmHi_r[3:1];

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (lcdTick) state_nxt = ST_FETCH;
      ST_FETCH: if (fetchIdx_r == `LSW_NIBS_PER_ROW) state_nxt = ST_SHOW;
      ST_SHOW:  state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  // fetch one row of nibbles, then present it with its row select
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r         <= ST_IDLE;
      row_r           <= 4'h0;
      fetchIdx_r      <= 4'h0;
      rowBuf_r        <= 56'h0000_0000_0000_00;
      columnDrive_r   <= 56'h0000_0000_0000_00;
      rowDrive_r      <= 16'h0000;
      lcdFrameClock_r <= 1'b0;
      lcdSyncOut_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (!wtRun) begin
        row_r        <= 4'h0;
        rowDrive_r   <= 16'h0000;
        lcdSyncOut_r <= 1'b0;
      end
      if (lcdTick)
        lcdFrameClock_r <= ~lcdFrameClock_r & lcd_control_register_r[`LSW_LC_CLKOUT];
      else if (!lcd_control_register_r[`LSW_LC_CLKOUT])
        lcdFrameClock_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          fetchIdx_r <= 4'h0;
          if (lcdTick)
            row_r <= nextRow;
        end
        ST_FETCH: begin
          fetchIdx_r <= fetchIdx_r + 4'h1;
          if (fetchIdx_r != 4'h0)
            rowBuf_r <= {scanNib, rowBuf_r[55:4]};
        end
        ST_SHOW: begin
          rowDrive_r   <= dispOn & wtRun ? rowOneHot(row_r) : 16'h0000;
          lcdSyncOut_r <= lcd_control_register_r[`LSW_LC_CLKOUT] & dispOn & wtRun
                          & (row_r == 4'h0);
          if (dispOn && dispMode == `LSW_DISP_ALL_ON)
            columnDrive_r <= {56{1'b1}};
          else if (dispOn && dispMode == `LSW_DISP_NORMAL)
            columnDrive_r <= rowBuf_r;
          else
            columnDrive_r <= 56'h0000_0000_0000_00;
        end
        default: fetchIdx_r <= 4'h0;
      endcase
    end
  end

  // released pins and bias control
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      columnPortRelease_r <= 4'h0;
      rowPortRelease_r    <= 16'h0000;
      biasCurrentOn_r     <= 1'b0;
      contrastMode_r      <= 2'h0;
    end else begin
      columnPortRelease_r <= ~(4'hF >> segPorts);
      if (lastRow == `LSW_ROWS_8)
        rowPortRelease_r <= 16'hFF00;
      else if (lastRow == `LSW_ROWS_12)
        rowPortRelease_r <= 16'hF000;
      else
        rowPortRelease_r <= 16'h0000;
      biasCurrentOn_r <= dispOn;
      contrastMode_r  <= lcd_control_register_r[1:0];
    end
  end

endmodule // lsw_scan_watch

// [verification/lsw_scan_watch_monitor.sv]
`timescale 1ns/10ps
module lsw_scan_watch_monitor (
  // clock and reset
  input wire        clk,
  input wire        sys_rst,
  // cpu side
  input wire [11:0] memAddr,
  input wire        memWrEn,
  input wire [1:0]  memWrMode,
  input wire [7:0]  memWrData,
  input wire        intervalFlagClr,
  // watched outputs
  input wire        watchIntervalFlag_r,
  input wire        toneOutputPin_r,
  input wire [15:0] rowDrive_r,
  input wire        biasCurrentOn_r,
  input wire [1:0]  contrastMode_r,
  input wire        lcdFrameClock_r,
  input wire        lcdSyncOut_r
);
  // shadows track byte writes only; the bench writes registers by byte
  reg  runQ_r;
  reg  toneQ_r;
  reg  clkOutQ_r;
  wire byteWr = memWrEn && memWrMode == 2'h2;
  wire [1:0] wrLow = memWrData[1:0];
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      runQ_r    <= 1'b0;
      toneQ_r   <= 1'b0;
      clkOutQ_r <= 1'b0;
    end else if (byteWr && memAddr == 12'h0F88) begin
      runQ_r    <= memWrData[2];
      toneQ_r   <= memWrData[7];
    end else if (byteWr && memAddr == 12'h0F8E) begin
      clkOutQ_r <= memWrData[2];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_flag_held: assert property (
    watchIntervalFlag_r && !intervalFlagClr |=> watchIntervalFlag_r)
    else $error("interval flag dropped without clear");
  a_start_flag: assert property (
    $rose(runQ_r) |-> ##[0:4] watchIntervalFlag_r)
    else $error("no interval flag at watch start");
  a_stop_blank: assert property (
    $fell(runQ_r) |-> ##[1:40] rowDrive_r == 16'h0)
    else $error("rows still driven after watch stop");
  a_row_onehot: assert property (
    rowDrive_r != 16'h0 |-> $onehot(rowDrive_r))
    else $error("more than one row driven");
  a_sync_row: assert property (
    lcdSyncOut_r |-> rowDrive_r[0])
    else $error("sync high away from first row");
  a_frame_gate: assert property (
    (!clkOutQ_r) [*3] |-> !lcdFrameClock_r)
    else $error("frame clock out while disabled");
  a_bias_mode: assert property (
    byteWr && memAddr == 12'h0F8E |-> ##2
      contrastMode_r == $past(wrLow, 2)
      && biasCurrentOn_r == (contrastMode_r != 2'h0))
    else $error("bias current does not follow mode");
  a_tone_gate: assert property (
    $fell(toneQ_r) |-> ##[0:300] !toneOutputPin_r)
    else $error("tone still out after disable");
endmodule // lsw_scan_watch_monitor

// [verification/lsw_panel_model.sv]
`timescale 1ns/10ps
module lsw_panel_model (
  // clock and capture clear
  input wire        clk,
  input wire        clearSeen,
  // glass and buzzer pins
  input wire [55:0] columnDrive_r,
  input wire [15:0] rowDrive_r,
  input wire        lcdFrameClock_r,
  input wire        lcdSyncOut_r,
  // port latch cleared and pin set to output by software
  input wire        toneOutputPin_r
);
  reg     [55:0] seen [0:15];
  reg     [15:0] rowsSeen;
  reg     [15:0] syncSeen;
  reg            toneQ;
  reg            fcQ;
  integer        fcEdges;
  integer        halfCyc;
  integer        runCyc;
  integer        n;
  initial begin
    rowsSeen = 16'h0;
    syncSeen = 16'h0;
    toneQ = 1'b0;
    fcQ = 1'b0;
    fcEdges = 0;
    halfCyc = 0;
    runCyc = 0;
  end
  always @(posedge clk) begin
    // a dot lights where its column bit is 1 while its row is driven
    for (n = 0; n < 16; n = n + 1)
      if (rowDrive_r[n]) seen[n] <= columnDrive_r;
    rowsSeen <= clearSeen ? 16'h0 : (rowsSeen | rowDrive_r);
    if (lcdSyncOut_r) syncSeen <= syncSeen | rowDrive_r;
    fcQ <= lcdFrameClock_r;
    if (fcQ != lcdFrameClock_r) fcEdges <= fcEdges + 1;
    // buzzer: cycles between level changes give the half period
    toneQ <= toneOutputPin_r;
    runCyc <= (toneQ != toneOutputPin_r) ? 1 : runCyc + 1;
    if (toneQ != toneOutputPin_r) halfCyc <= runCyc;
  end
endmodule // lsw_panel_model

// [verification/test_lcd_scan_and_watch_timer.sv]
`timescale 1ns/10ps
module test_lcd_scan_and_watch_timer;
  // stimulus
  reg         clk;
  reg         sys_rst;
  reg  [11:0] memAddr;
  reg         memWrEn;
  reg  [1:0]  memWrMode;
  reg  [1:0]  memBitSel;
  reg  [7:0]  memWrData;
  reg         mainOscTick;
  reg         subOscInputPin;
  reg         intervalFlagClr;
  reg         clearSeen;
  reg         subOn;
  // design outputs
  wire [7:0]  memRdData_r;
  wire        watchIntervalFlag_r;
  wire        toneOutputPin_r;
  wire [55:0] columnDrive_r;
  wire [15:0] rowDrive_r;
  wire [3:0]  columnPortRelease_r;
  wire [15:0] rowPortRelease_r;
  wire        biasCurrentOn_r;
  wire [1:0]  contrastMode_r;
  wire        lcdFrameClock_r;
  wire        lcdSyncOut_r;
  integer     n_fail;
  integer     compares;
  integer     i;
  integer     j;
  integer     cnt;
  reg  [55:0] expCol;

  lsw_scan_watch dut_u (.clk, .sys_rst, .memAddr, .memWrEn, .memWrMode,
    .memBitSel, .memWrData, .memRdData_r, .mainOscTick, .subOscInputPin,
    .watchIntervalFlag_r, .intervalFlagClr, .toneOutputPin_r,
    .columnDrive_r, .rowDrive_r, .columnPortRelease_r, .rowPortRelease_r,
    .biasCurrentOn_r, .contrastMode_r, .lcdFrameClock_r, .lcdSyncOut_r);
  lsw_panel_model glass_u (.clk, .clearSeen, .columnDrive_r, .rowDrive_r,
    .lcdFrameClock_r, .lcdSyncOut_r, .toneOutputPin_r);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // crystal scaled to four system clocks a cycle to keep runs short
  initial forever #20 if (subOn) subOscInputPin = ~subOscInputPin;

  task check(input string what, input [63:0] got, input [63:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task near(input string what, input integer got, exp, tol);
    check(what, (got >= exp - tol && got <= exp + tol), 1'b1);
  endtask
  // bit writes take the bit index from d[5:4] and the value from d[0]
  task wr(input [11:0] a, input [1:0] m, input [7:0] d);
    begin
      @(posedge clk);
      #1 memAddr = a;
      memWrMode = m;
      memWrData = d;
      memBitSel = d[5:4];
      memWrEn = 1'b1;
      @(posedge clk);
      #1 memWrEn = 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [7:0] e);
    begin
      @(posedge clk);
      #1 memAddr = a;
      @(posedge clk);
      #1 check("readback", memRdData_r, e);
    end
  endtask
  task waitFlag(input integer lim);
    begin
      cnt = 0;
      while (watchIntervalFlag_r !== 1'b1 && cnt < lim) begin
        @(posedge clk);
        #1 cnt = cnt + 1;
      end
      if (cnt >= lim) begin
        n_fail = n_fail + 1;
        $display("ERROR interval flag expected 1 seen 0");
        finish_test;
      end
    end
  endtask
  task clrFlag;
    begin
      @(posedge clk);
      #1 intervalFlagClr = 1'b1;
      @(posedge clk);
      #1 intervalFlagClr = 1'b0;
    end
  endtask
  task duty(input [7:0] lm, lc, input [15:0] rows, rel, input [3:0] cr);
    begin
      wr(12'h0F8C, 2'h2, lm);
      wr(12'h0F8E, 2'h2, lc);
      repeat (100) @(posedge clk);
      #1 clearSeen = 1'b1;
      @(posedge clk);
      #1 clearSeen = 1'b0;
      repeat (1200) @(posedge clk);
      #1 check("rows scanned", glass_u.rowsSeen, rows);
      check("row release", rowPortRelease_r, rel);
      check("column release", columnPortRelease_r, cr);
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  initial begin
    n_fail = 0;
    compares = 0;
    sys_rst = 1'b1;
    memAddr = 12'h0;
    memWrEn = 1'b0;
    memWrMode = 2'h0;
    memBitSel = 2'h0;
    memWrData = 8'h0;
    mainOscTick = 1'b0;
    subOscInputPin = 1'b1;
    intervalFlagClr = 1'b0;
    clearSeen = 1'b0;
    subOn = 1'b0;
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    // level bit reaches the register through two flops
    repeat (2) @(posedge clk);
    rd(12'h0F88, 8'h08);
    check("row release", rowPortRelease_r, 16'hFF00);
    subOscInputPin = 1'b0;
    repeat (3) @(posedge clk);
    rd(12'h0F88, 8'h00);
    wr(12'h0F88, 2'h2, 8'hFF);
    rd(12'h0F88, 8'hB7);
    wr(12'h0F88, 2'h2, 8'h00);
    clrFlag;
    $display("test reset and readback done");
    subOn = 1'b1;
    wr(12'h0F88, 2'h2, 8'h07);
    waitFlag(8);
    clrFlag;
    waitFlag(700);
    near("fast interval", cnt, 512, 12);
    wr(12'h0F88, 2'h2, 8'h00);
    clrFlag;
    wr(12'h0F88, 2'h2, 8'h05);
    waitFlag(8);
    clrFlag;
    repeat (1500) @(posedge clk);
    #1 check("normal flag", watchIntervalFlag_r, 1'b0);
    wr(12'h0F88, 2'h2, 8'h00);
    mainOscTick = 1'b1;
    wr(12'h0F88, 2'h2, 8'h06);
    waitFlag(8);
    clrFlag;
    waitFlag(17000);
    near("main interval", cnt, 16384, 200);
    mainOscTick = 1'b0;
    $display("test interval flag done");
    for (i = 0; i < 4; i = i + 1) begin
      wr(12'h0F88, 2'h2, {2'h2, i[1:0], 4'h5});
      repeat (80) @(posedge clk);
      near("tone half", glass_u.halfCyc, 4 << (3 - i), 2);
    end
    wr(12'h0F88, 2'h2, 8'h05);
    repeat (100) @(posedge clk);
    #1 check("tone off", toneOutputPin_r, 1'b0);
    $display("test buzzer done");
    for (i = 0; i < 16; i = i + 1)
      for (j = 0; j < 14; j = j + 2)
        wr({4'h2, i[3:0], j[3:0]}, 2'h2, {4'(i + j + 1), 4'(i + j)});
    wr(12'h02FD, 2'h1, 8'h0A);
    wr(12'h0253, 2'h0, 8'h21);
    duty(8'h1F, 8'h07, 16'hFFFF, 16'h0000, 4'h0);
    for (i = 0; i < 16; i = i + 1) begin
      for (j = 0; j < 14; j = j + 1)
        expCol[4*j +: 4] = 4'(i + j);
      if (i == 15) expCol[55:52] = 4'hA;
      if (i == 5) expCol[15:12] = 4'hC;
      check("row columns", glass_u.seen[i], expCol);
    end
    check("frame clock", glass_u.fcEdges != 0, 1'b1);
    check("bias on", biasCurrentOn_r, 1'b1);
    check("contrast", contrastMode_r, 2'h3);
    check("sync row", glass_u.syncSeen, 16'h0001);
    duty(8'h1B, 8'h07, 16'h00FF, 16'hFF00, 4'h0);
    duty(8'h7F, 8'h0F, 16'h0FFF, 16'hF000, 4'hE);
    duty(8'h9F, 8'h07, 16'hFFFF, 16'h0000, 4'hF);
    duty(8'h1D, 8'h07, 16'hFFFF, 16'h0000, 4'h0);
    check("all dots", glass_u.seen[3], {56{1'b1}});
    wr(12'h0F8E, 2'h2, 8'h00);
    repeat (60) @(posedge clk);
    #1 check("display off", rowDrive_r, 16'h0);
    check("bias off", biasCurrentOn_r, 1'b0);
    check("contrast off", contrastMode_r, 2'h0);
    wr(12'h0F8E, 2'h2, 8'h07);
    wr(12'h0F88, 2'h2, 8'h00);
    repeat (60) @(posedge clk);
    #1 check("watch stop", rowDrive_r, 16'h0);
    $display("test display done");
    finish_test;
  end
endmodule // test_lcd_scan_and_watch_timer

bind lsw_scan_watch lsw_scan_watch_monitor mon_u (.clk, .sys_rst, .memAddr,
  .memWrEn, .memWrMode, .memWrData, .intervalFlagClr, .watchIntervalFlag_r,
  .toneOutputPin_r, .rowDrive_r, .biasCurrentOn_r, .contrastMode_r,
  .lcdFrameClock_r, .lcdSyncOut_r);
